//--- logic/rf_pkg.sv
// What this block does
// - Exactly two processor modes, user and privileged, decide which registers are reachable.
// - Runs in user mode normally; an exception or accepted interrupt enters privileged mode.
// - Sixteen general registers, R0 to R15, are visible in either mode.
// - R0 to R7 exist twice, bank 0 and bank 1; R8 to R15 once.
// - Privileged with bank select 1: R0-R7 are bank 1; bank 0 only via control access.
// - Privileged with bank select 0: R0-R7 are bank 0; bank 1 only via control access.
// - User mode: R0-R15 are bank 0 plus R8-R15; bank 1 never reachable.
// - Global base pointer and status word in both modes; saved and vector registers privileged only.
// - Status word bits such as bank select change only in privileged mode.
// - Multiply-accumulate pair, link register and program counter are never gated by mode.
// - The privilege mode bit of the status word selects the mode and the visibility.
// - Reset status word: mode, bank select, block bits 1, mask all ones, reserved zero.
// - Reset loads the program counter start address and clears the vector base pointer.
`default_nettype none

package rf_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets inside the slave window)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_GEN    = 8'h00;  // R0..R15, current view
  localparam logic [7:0] OFF_BANK0  = 8'h40;  // Bank 0 direct (control access)
  localparam logic [7:0] OFF_BANK1  = 8'h60;  // Bank 1 direct (control access)
  localparam logic [7:0] OFF_STATUS = 8'h80;
  localparam logic [7:0] OFF_GBP    = 8'h84;
  localparam logic [7:0] OFF_SSW    = 8'h88;
  localparam logic [7:0] OFF_SPC    = 8'h8c;
  localparam logic [7:0] OFF_VBP    = 8'h90;
  localparam logic [7:0] OFF_MULTIPLY_ACCUM_HIGH   = 8'h94;
  localparam logic [7:0] OFF_MULTIPLY_ACCUM_LOW   = 8'h98;
  localparam logic [7:0] OFF_LINK   = 8'h9c;
  localparam logic [7:0] OFF_PC     = 8'ha0;
  localparam logic [7:0] OFF_ACCESS = 8'ha4;  // Bit 0: sticky refused-access flag

  // ----------------------------------------------------------------
  // Status word fields
  // ----------------------------------------------------------------
  localparam int unsigned MD_BIT = 30;
  localparam int unsigned RB_BIT = 29;
  localparam int unsigned BL_BIT = 28;
  localparam logic [31:0] PRIV_ONLY_MASK = 32'h700000f0;  // Mode, bank, block, mask level
  localparam logic [31:0] USER_MASK      = 32'h00000303;  // Arithmetic flags
  localparam logic [31:0] PRIV_MASK      = 32'h700003f3;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [31:0] STATUS_RST = 32'h700000f0;
  localparam logic [31:0] PC_RST     = 32'h0a000000;
  localparam logic [31:0] VBP_RST    = 32'h00000000;
  localparam logic [31:0] ZERO_RST   = 32'h00000000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;          // One-cycle exception or accepted interrupt
    logic [31:0] vector_offset;  // Added to the vector base pointer
  } exc_req_s;

  typedef struct packed {
    logic priv;   // Privilege mode bit
    logic bank;   // Bank select bit
    logic block;  // Exception block bit
  } mode_status_s;

endpackage : rf_pkg

`default_nettype wire

//--- logic/gpr_array.sv
`default_nettype none

// ------------------------------------------------------------------
// General register storage: bank 0, bank 1, then the unbanked copies
// ------------------------------------------------------------------
module gpr_array #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 24,
  parameter int unsigned AW    = 5
) (
  // Clock
  input  wire logic             hclk,
  // Write port
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // Read port
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  // Slots are addressed directly; a short index would alias banks
  if (DEPTH > (1 << AW) || DEPTH < 24) begin : g_bad_depth
    $error("gpr_array: DEPTH must be at least 24 and fit in AW bits");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  // No reset: general registers come up undefined, which saves area
  always_ff @(posedge hclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Combinational read, captured by the caller's data flop
  assign rdata = mem[raddr];

endmodule : gpr_array

`default_nettype wire

//--- logic/banked_cpu_register_file.sv
// Design decisions made here: the register addresses and the AHB-Lite register port.
`default_nettype none

module banked_cpu_register_file (
  // Clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic      [31:0]          hrdata,
  // Core side
  input  wire rf_pkg::exc_req_s     exc_req,
  output rf_pkg::mode_status_s      mode_status
);

  // ----------------------------------------------------------------
  // Address phase capture
  // ----------------------------------------------------------------
  logic        wr_q;
  logic        rd_pend_q;
  logic        map_q;
  logic [5:0]  aidx_q;
  logic        accept;
  logic        word_ok;

  // Only whole-word writes take effect; other write sizes are ignored, reads are served at any size
  assign word_ok = (hsize == 3'b010);
  assign accept  = hsel && htrans[1] && hready;

  // Reads take one wait state so a read right after a write sees it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q      <= 1'b0;
      rd_pend_q <= 1'b0;
      map_q     <= 1'b0;
      aidx_q    <= 6'h00;
    end else begin
      wr_q      <= accept && hwrite && word_ok;
      rd_pend_q <= accept && !hwrite;
      if (accept) begin
        map_q  <= (haddr[31:8] == 24'h000000) && (haddr[7:0] <= rf_pkg::OFF_ACCESS);
        aidx_q <= haddr[7:2];
      end
    end
  end

  assign hreadyout = !rd_pend_q;
  assign hresp     = 1'b0;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] sr_q;
  logic [31:0] gbp_q;
  logic [31:0] ssw_q;
  logic [31:0] spc_q;
  logic [31:0] vbp_q;
  logic [31:0] multiply_accum_high_q;
  logic [31:0] multiply_accum_low_q;
  logic [31:0] link_q;
  logic [31:0] pc_q;
  logic        denied_q;
  logic [31:0] hrdata_q;

  wire md = sr_q[rf_pkg::MD_BIT];
  wire rb = sr_q[rf_pkg::RB_BIT];

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Slot 0-7 bank 0, 8-15 bank 1, 16-23 unbanked R8-R15
  function automatic logic [4:0] slot_of(input logic [5:0] idx,
                                         input logic       priv,
                                         input logic       bsel);
    if (idx[5:4] == 2'b01) begin
      slot_of = {1'b0, idx[3], idx[2:0]};            // Direct bank access
    end else if (idx[3]) begin
      slot_of = {2'b10, idx[2:0]};
    end else if (priv && bsel) begin
      slot_of = {2'b01, idx[2:0]};
    end else begin
      slot_of = {2'b00, idx[2:0]};
    end
  endfunction

  logic [4:0]  slot;
  logic        gen_hit;
  logic        bk_hit;
  logic        sr_hit;
  logic        gbp_hit;
  logic        ssw_hit;
  logic        spc_hit;
  logic        vbp_hit;
  logic        multiply_accum_high_hit;
  logic        multiply_accum_low_hit;
  logic        link_hit;
  logic        pc_hit;
  logic        acc_hit;
  logic        denied;
  logic        wr_en;
  logic [31:0] gpr_rdata;

  // Register hits from the latched word index
  assign slot     = slot_of(aidx_q, md, rb);
  assign gen_hit  = map_q && (aidx_q[5:4] == 2'b00);
  assign bk_hit   = map_q && (aidx_q[5:4] == 2'b01);
  assign sr_hit   = map_q && (aidx_q == rf_pkg::OFF_STATUS[7:2]);
  assign gbp_hit  = map_q && (aidx_q == rf_pkg::OFF_GBP[7:2]);
  assign ssw_hit  = map_q && (aidx_q == rf_pkg::OFF_SSW[7:2]);
  assign spc_hit  = map_q && (aidx_q == rf_pkg::OFF_SPC[7:2]);
  assign vbp_hit  = map_q && (aidx_q == rf_pkg::OFF_VBP[7:2]);
  assign multiply_accum_high_hit = map_q && (aidx_q == rf_pkg::OFF_MULTIPLY_ACCUM_HIGH[7:2]);
  assign multiply_accum_low_hit = map_q && (aidx_q == rf_pkg::OFF_MULTIPLY_ACCUM_LOW[7:2]);
  assign link_hit = map_q && (aidx_q == rf_pkg::OFF_LINK[7:2]);
  assign pc_hit   = map_q && (aidx_q == rf_pkg::OFF_PC[7:2]);
  assign acc_hit  = map_q && (aidx_q == rf_pkg::OFF_ACCESS[7:2]);

  // User mode may not touch either bank directly nor the saved and vector registers
  assign denied = !md && (bk_hit || ssw_hit || spc_hit || vbp_hit);
  assign wr_en  = wr_q && !denied;

  gpr_array #(
    .WIDTH (32),
    .DEPTH (24),
    .AW    (5)
  ) u_gpr (
    .hclk  (hclk),
    .we    (wr_en && (gen_hit || bk_hit)),
    .waddr (slot),
    .wdata (hwdata),
    .raddr (slot),
    .rdata (gpr_rdata)
  );

  // ----------------------------------------------------------------
  // Status word and exception entry
  // ----------------------------------------------------------------
  logic [31:0] sr_wmask;
  logic [31:0] sr_wval;

  // User writes reach the arithmetic flags only
  assign sr_wmask = md ? rf_pkg::PRIV_MASK : rf_pkg::USER_MASK;
  assign sr_wval  = (sr_q & ~sr_wmask) | (hwdata & sr_wmask);

  // Exception entry wins over a bus write in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sr_q <= rf_pkg::STATUS_RST;
    end else if (exc_req.valid) begin
      sr_q <= sr_q | (32'h00000001 << rf_pkg::MD_BIT) | (32'h00000001 << rf_pkg::RB_BIT)
                   | (32'h00000001 << rf_pkg::BL_BIT);
    end else if (wr_en && sr_hit) begin
      sr_q <= sr_wval;
    end
  end

  // Saved copies are taken on entry; the bus may rewrite them when privileged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ssw_q <= rf_pkg::ZERO_RST;
      spc_q <= rf_pkg::ZERO_RST;
    end else if (exc_req.valid) begin
      ssw_q <= sr_q;
      spc_q <= pc_q;
    end else begin
      if (wr_en && ssw_hit) ssw_q <= hwdata;
      if (wr_en && spc_hit) spc_q <= hwdata;
    end
  end

  // Program counter jumps to the vector on entry
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_q <= rf_pkg::PC_RST;
    end else if (exc_req.valid) begin
      pc_q <= vbp_q + exc_req.vector_offset;
    end else if (wr_en && pc_hit) begin
      pc_q <= hwdata;
    end
  end

  // Vector base pointer, privileged only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vbp_q <= rf_pkg::VBP_RST;
    end else if (wr_en && vbp_hit) begin
      vbp_q <= hwdata;
    end
  end

  // Mode-independent registers; the gbp has a defined reset for safety
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gbp_q  <= rf_pkg::ZERO_RST;
      multiply_accum_high_q <= rf_pkg::ZERO_RST;
      multiply_accum_low_q <= rf_pkg::ZERO_RST;
      link_q <= rf_pkg::ZERO_RST;
    end else begin
      if (wr_en && gbp_hit)  gbp_q  <= hwdata;
      if (wr_en && multiply_accum_high_hit) multiply_accum_high_q <= hwdata;
      if (wr_en && multiply_accum_low_hit) multiply_accum_low_q <= hwdata;
      if (wr_en && link_hit) link_q <= hwdata;
    end
  end

  // ----------------------------------------------------------------
  // Refused-access flag
  // ----------------------------------------------------------------
  logic deny_evt;
  logic deny_clr;

  assign deny_evt = (wr_q || rd_pend_q) && denied;
  assign deny_clr = wr_q && acc_hit && hwdata[0];

  // A refusal in the clearing cycle is kept: set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      denied_q <= 1'b0;
    end else begin
      denied_q <= deny_evt || (denied_q && !deny_clr);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] rd_val;

  // Refused and unmapped reads return zero
  assign rd_val = denied                    ? 32'h00000000 :
                  (gen_hit || bk_hit)       ? gpr_rdata    :
                  sr_hit                    ? sr_q         :
                  gbp_hit                   ? gbp_q        :
                  ssw_hit                   ? ssw_q        :
                  spc_hit                   ? spc_q        :
                  vbp_hit                   ? vbp_q        :
                  multiply_accum_high_hit                  ? multiply_accum_high_q       :
                  multiply_accum_low_hit                  ? multiply_accum_low_q       :
                  link_hit                  ? link_q       :
                  pc_hit                    ? pc_q         :
                  acc_hit                   ? {31'h00000000, denied_q} :
                                              32'h00000000;

  // Captured in the wait cycle so the value is stable in the ready cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
    end else if (rd_pend_q) begin
      hrdata_q <= rd_val;
    end
  end

  assign hrdata            = hrdata_q;
  assign mode_status.priv  = sr_q[rf_pkg::MD_BIT];
  assign mode_status.bank  = sr_q[rf_pkg::RB_BIT];
  assign mode_status.block = sr_q[rf_pkg::BL_BIT];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_gen_low_write;
    wr_en && gen_hit && !aidx_q[3];
  endsequence

  sequence s_read_accept;
    accept && !hwrite;
  endsequence

  property p_exc_enters_priv;
    @(posedge hclk) disable iff (!hresetn)
    exc_req.valid |=> mode_status.priv && mode_status.bank && mode_status.block
                      && (ssw_q == $past(sr_q)) && (spc_q == $past(pc_q));
  endproperty
  a_exc_enters_priv: assert property (p_exc_enters_priv) else $error("entry did not set mode");

  property p_rb1_bank1;
    @(posedge hclk) disable iff (!hresetn)
    (s_gen_low_write and (md && rb)) |-> (slot == {2'b01, aidx_q[2:0]});
  endproperty
  a_rb1_bank1: assert property (p_rb1_bank1) else $error("bank 1 not selected");

  property p_rb0_bank0;
    @(posedge hclk) disable iff (!hresetn)
    (s_gen_low_write and (md && !rb)) |-> (slot == {2'b00, aidx_q[2:0]});
  endproperty
  a_rb0_bank0: assert property (p_rb0_bank0) else $error("bank 0 not selected");

  property p_user_no_bank1;
    @(posedge hclk) disable iff (!hresetn)
    (wr_en && (gen_hit || bk_hit) && !md) |-> (slot[4:3] != 2'b01);
  endproperty
  a_user_no_bank1: assert property (p_user_no_bank1) else $error("user reached bank 1");

  property p_user_sr_guard;
    @(posedge hclk) disable iff (!hresetn)
    (wr_q && sr_hit && !md && !exc_req.valid)
      |=> ((sr_q & rf_pkg::PRIV_ONLY_MASK) == ($past(sr_q) & rf_pkg::PRIV_ONLY_MASK));
  endproperty
  a_user_sr_guard: assert property (p_user_sr_guard) else $error("user changed guarded bits");

  property p_user_vbp_locked;
    @(posedge hclk) disable iff (!hresetn)
    (wr_q && vbp_hit && !md) |=> $stable(vbp_q) && denied_q;
  endproperty
  a_user_vbp_locked: assert property (p_user_vbp_locked) else $error("user wrote vector base");

  property p_multiply_accum_low_free;
    @(posedge hclk) disable iff (!hresetn)
    (wr_q && multiply_accum_low_hit) |=> (multiply_accum_low_q == $past(hwdata));
  endproperty
  a_multiply_accum_low_free: assert property (p_multiply_accum_low_free) else $error("multiply_accum_low write lost");

  property p_md_clear_to_user;
    @(posedge hclk) disable iff (!hresetn)
    (wr_q && sr_hit && md && !hwdata[rf_pkg::MD_BIT] && !exc_req.valid) |=> !mode_status.priv;
  endproperty
  a_md_clear_to_user: assert property (p_md_clear_to_user) else $error("mode bit not cleared");

  property p_read_one_wait;
    @(posedge hclk) disable iff (!hresetn)
    s_read_accept |=> !hreadyout ##1 (hreadyout && (hrdata == $past(rd_val)));
  endproperty
  a_read_one_wait: assert property (p_read_one_wait) else $error("read wait state wrong");

endmodule : banked_cpu_register_file

`default_nettype wire

//--- verification/banked_cpu_register_file_tb.sv
`default_nettype none

module banked_cpu_register_file_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  logic                 hclk;
  logic                 hresetn;
  logic                 hsel;
  logic [31:0]          haddr;
  logic [1:0]           htrans;
  logic                 hwrite;
  logic [2:0]           hsize;
  logic [31:0]          hwdata;
  logic                 hreadyout;
  logic                 hresp;
  logic [31:0]          hrdata;
  rf_pkg::exc_req_s     exc_req;
  rf_pkg::mode_status_s mode_status;
  logic [31:0]          bank0_m [8];
  logic [31:0]          bank1_m [8];
  logic [31:0]          high_m [8];
  logic [31:0]          status_m, gbp_m, ssw_m, spc_m, vbp_m, multiply_accum_high_m, multiply_accum_low_m, link_m, pc_m;
  logic                 flag_m;
  logic [31:0]          rnd_q;
  int                   n_mismatch;
  int                   check_count;
  int                   cyc_q;

  banked_cpu_register_file dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .exc_req(exc_req), .mode_status(mode_status)
  );

  // Free-running bus clock, 20 ns period
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    rnd_q = {rnd_q[30:0], rnd_q[31] ^ rnd_q[21] ^ rnd_q[1] ^ rnd_q[0]};
    return rnd_q;
  endfunction

  function automatic logic [31:0] at(input logic [7:0] o, input int i);
    return {24'h0, o + 8'(4 * i)};
  endfunction

  task automatic finish_test();
    if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Refused in user mode: direct banks and the saved and vector registers
  function automatic logic refused(input logic [7:0] o);
    return !status_m[rf_pkg::MD_BIT] && ((o >= 8'h40 && o < 8'h80) || o == 8'h88 || o == 8'h8c || o == 8'h90);
  endfunction

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  task automatic m_reset();
    status_m = rf_pkg::STATUS_RST;
    pc_m     = rf_pkg::PC_RST;
    vbp_m    = rf_pkg::VBP_RST;
    {gbp_m, ssw_m, spc_m, multiply_accum_high_m, multiply_accum_low_m, link_m} = {6{rf_pkg::ZERO_RST}};
    flag_m   = 1'b0;
  endtask

  function automatic logic [31:0] m_read(input logic [31:0] a);
    logic [7:0] o;
    logic       b1;
    o  = a[7:0];
    b1 = status_m[rf_pkg::MD_BIT] && status_m[rf_pkg::RB_BIT];
    if (a[31:8] != 24'h0 || o > 8'ha4) return 32'h0;
    if (refused(o)) begin
      flag_m = 1'b1;
      return 32'h0;
    end
    if (o < 8'h40) return o[5] ? high_m[o[4:2]] : (b1 ? bank1_m[o[4:2]] : bank0_m[o[4:2]]);
    if (o < 8'h60) return bank0_m[o[4:2]];
    if (o < 8'h80) return bank1_m[o[4:2]];
    case (o)
      8'h80:   return status_m;
      8'h84:   return gbp_m;
      8'h88:   return ssw_m;
      8'h8c:   return spc_m;
      8'h90:   return vbp_m;
      8'h94:   return multiply_accum_high_m;
      8'h98:   return multiply_accum_low_m;
      8'h9c:   return link_m;
      8'ha0:   return pc_m;
      8'ha4:   return {31'h0, flag_m};
      default: return 32'h0;
    endcase
  endfunction

  task automatic m_write(input logic [31:0] a, input logic [31:0] d);
    logic [7:0] o;
    o = a[7:0];
    if (a[31:8] != 24'h0 || o > 8'ha4) return;
    if (refused(o)) begin
      flag_m = 1'b1;
      return;
    end
    if (o < 8'h40 && o[5]) high_m[o[4:2]] = d;
    else if (o < 8'h40 && status_m[rf_pkg::MD_BIT] && status_m[rf_pkg::RB_BIT]) bank1_m[o[4:2]] = d;
    else if (o < 8'h60) bank0_m[o[4:2]] = d;
    else if (o < 8'h80) bank1_m[o[4:2]] = d;
    case (o)
      8'h80: status_m = status_m[rf_pkg::MD_BIT] ? (d & rf_pkg::PRIV_MASK) :
                        ((status_m & ~rf_pkg::USER_MASK) | (d & rf_pkg::USER_MASK));
      8'h84: gbp_m  = d;
      8'h88: ssw_m  = d;
      8'h8c: spc_m  = d;
      8'h90: vbp_m  = d;
      8'h94: multiply_accum_high_m = d;
      8'h98: multiply_accum_low_m = d;
      8'h9c: link_m = d;
      8'ha0: pc_m   = d;
      8'ha4: if (d[0]) flag_m = 1'b0;
      default: ;
    endcase
  endtask

  // ----------------------------------------------------------------
  // Bus master: address phase held until hready, then data phase
  // ----------------------------------------------------------------
  task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] junk;
    ahb_xfer(1'b1, a, d, junk);
    m_write(a, d);
  endtask

  task automatic rd(input logic [31:0] a);
    logic [31:0] got;
    ahb_xfer(1'b0, a, rnd(), got);
    chk(got, m_read(a));
    chk({31'h0, hresp}, 32'h0);
  endtask

  // Exception requests on n consecutive edges; each one sees the previous result
  task automatic take_exc(input int n);
    logic [31:0] off;
    for (int k = 0; k < n; k++) begin
      off = rnd();
      exc_req <= '{valid: 1'b1, vector_offset: off};
      @(posedge hclk);
      ssw_m    = status_m;
      spc_m    = pc_m;
      status_m = status_m | 32'h70000000;
      pc_m     = vbp_m + off;
    end
    exc_req.valid <= 1'b0;
  endtask

  // Cycle ceiling against hangs
  always @(posedge hclk) begin
    cyc_q <= cyc_q + 1;
    if (cyc_q == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] ctl [9];
    logic [7:0] bad [5];
    ctl = '{8'h84, 8'h88, 8'h8c, 8'h90, 8'h94, 8'h98, 8'h9c, 8'ha0, 8'h84};
    bad = '{8'h40, 8'h7c, 8'h88, 8'h8c, 8'h90};
    {hresetn, hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
    exc_req     = '0;
    rnd_q       = 32'd91702;
    n_mismatch  = 0;
    check_count = 0;
    cyc_q       = 0;
    m_reset();
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(32'(mode_status), 32'h7);
    rd({24'h0, rf_pkg::OFF_STATUS});
    rd({24'h0, rf_pkg::OFF_PC});
    rd({24'h0, rf_pkg::OFF_VBP});
    // Privileged, bank 1 in view: fill view and bank 0, then cross-read
    for (int i = 0; i < 16; i++) wr(at(rf_pkg::OFF_GEN, i), rnd());
    for (int i = 0; i < 8; i++) wr(at(rf_pkg::OFF_BANK0, i), rnd());
    for (int i = 0; i < 16; i++) rd(at(rf_pkg::OFF_GEN, i));
    for (int i = 0; i < 8; i++) rd(at(rf_pkg::OFF_BANK1, i));
    // Privileged, bank 0 in view
    wr({24'h0, rf_pkg::OFF_STATUS}, 32'h40000000 | (rnd() & 32'h0fffffff));
    rd({24'h0, rf_pkg::OFF_STATUS});
    for (int i = 0; i < 16; i++) rd(at(rf_pkg::OFF_GEN, i));
    for (int i = 0; i < 4; i++) wr(at(rf_pkg::OFF_GEN, i), rnd());
    for (int i = 0; i < 8; i++) rd(at(rf_pkg::OFF_BANK0, i));
    for (int i = 0; i < 8; i++) rd(at(rf_pkg::OFF_BANK1, i));
    // Control and system registers, back-to-back write and read
    for (int i = 0; i < 8; i++) begin
      wr({24'h0, ctl[i]}, rnd());
      rd({24'h0, ctl[i]});
    end
    // Drop to user mode with the bank bit still set
    wr({24'h0, rf_pkg::OFF_STATUS}, 32'h200000f0 | (rnd() & 32'h303));
    #1;
    chk(32'(mode_status), {29'h0, status_m[30:28]});
    for (int i = 0; i < 16; i++) rd(at(rf_pkg::OFF_GEN, i));
    for (int i = 0; i < 8; i++) wr(at(rf_pkg::OFF_GEN, i), rnd());
    wr({24'h0, rf_pkg::OFF_STATUS}, 32'hffffffff);
    rd({24'h0, rf_pkg::OFF_STATUS});
    chk(32'(mode_status), {29'h0, status_m[30:28]});
    for (int i = 0; i < 5; i++) begin
      wr({24'h0, bad[i]}, rnd());
      rd({24'h0, bad[i]});
    end
    rd({24'h0, rf_pkg::OFF_ACCESS});
    for (int i = 4; i < 9; i++) begin
      wr({24'h0, ctl[i]}, rnd());
      rd({24'h0, ctl[i]});
    end
    // Two exceptions on consecutive edges from user mode
    take_exc(2);
    #1;
    chk(32'(mode_status), 32'h7);
    for (int i = 0; i < 5; i++) rd({24'h0, ctl[i]});
    rd({24'h0, rf_pkg::OFF_STATUS});
    for (int i = 0; i < 8; i++) rd(at(rf_pkg::OFF_BANK0, i));
    for (int i = 0; i < 8; i++) rd(at(rf_pkg::OFF_GEN, i));
    // Sticky flag clear, then unmapped places leave it clear
    wr({24'h0, rf_pkg::OFF_ACCESS}, 32'h1);
    rd(32'h000000a8);
    wr(32'h00000104, rnd());
    rd(32'h00000104);
    rd({24'h0, rf_pkg::OFF_ACCESS});
    // Reset in mid-run restores the start state
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    m_reset();
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(32'(mode_status), 32'h7);
    rd({24'h0, rf_pkg::OFF_STATUS});
    rd({24'h0, rf_pkg::OFF_PC});
    rd({24'h0, rf_pkg::OFF_VBP});
    finish_test();
  end

endmodule // banked_cpu_register_file_tb

`default_nettype wire
